//--- include/rvm_defines.vh
// Purpose: Offsets, field positions and widths of the rail voltage/mode registers
// Assumes: 8-bit register port, byte offsets as printed
// Notes: Factory defaults come in on the default inputs, not from here
`ifndef RVM_DEFINES_VH
`define RVM_DEFINES_VH

// ==========================================================================
// Register offsets
`define RVM_OFF_RAIL6_NORMAL 8'h98
`define RVM_OFF_RAIL6_SLEEP 8'h99
`define RVM_OFF_LDO2 8'h9A
`define RVM_OFF_LDO3 8'h9B
`define RVM_OFF_RAILS123 8'h9C

// ==========================================================================
// Field positions
`define RVM_CODE7_HI 7
`define RVM_CODE7_LO 1
`define RVM_FALL_BIT 0
`define RVM_SLP4_HI 7
`define RVM_SLP4_LO 4
`define RVM_NRM4_HI 3
`define RVM_NRM4_LO 0
`define RVM_PWM_HI 5
`define RVM_PWM_LO 3
`define RVM_ALLOW_HI 2
`define RVM_ALLOW_LO 0

// ==========================================================================
// Reserved-bit masks and unmapped read value
`define RVM_SLEEP_MASK 8'hFE
`define RVM_FULL_MASK 8'hFF
`define RVM_CTRL_MASK 8'h3F
`define RVM_UNMAPPED 8'h00

`endif

//--- hw/rvm_reg8.v
// Purpose: One 8-bit register with writable-bit mask and default load
// Assumes: Default value is stable while reset is asserted
// Notes: Reserved bits (mask 0) always hold zero
module rvm_reg8 #(
	parameter [7:0] MASK = 8'hFF
) (
	input wire clock_i,
	input wire rst_b_i,
	input wire load_i,
	input wire [7:0] dflt_i,
	input wire wr_i,
	input wire [7:0] wdata_i,
	output reg [7:0] q_o
);

	// ======================================================================
	// Storage: cleared asynchronously, then loaded with default
	always @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			q_o <= 8'h00;
		end else if (load_i) begin
			q_o <= dflt_i & MASK;
		end else if (wr_i) begin
			q_o <= wdata_i & MASK;
		end
	end

endmodule // rvm_reg8

//--- hw/rvm_regs.v
// Purpose: Rail voltage codes and mode/disable registers of a multi-rail PMU
// Assumes: Register port on clock_i; defaults strapped by factory fuses
// Notes: Defaults latch on the first clock after reset release
`include "rvm_defines.vh"

module rvm_regs (
	input wire clock_i,
	input wire rst_b_i,
	input wire [7:0] addr_i,
	input wire wr_en_i,
	input wire rd_en_i,
	input wire [7:0] wdata_i,
	input wire [7:0] dflt_rail6_normal_i,
	input wire [7:0] dflt_rail6_sleep_i,
	input wire [7:0] dflt_ldo2_i,
	input wire [7:0] dflt_ldo3_i,
	input wire [7:0] dflt_rails123_i,
	input wire rail6_sleep_i,
	input wire ldo2_sleep_i,
	input wire ldo3_sleep_i,
	input wire [2:0] rails123_enable_req_i,
	output reg [7:0] rdata_o,
	output reg [6:0] rail6_code_o,
	output reg rail6_passive_fall_o,
	output reg [3:0] ldo2_code_o,
	output reg [3:0] ldo3_code_o,
	output reg [2:0] rails123_pwm_force_o,
	output reg [2:0] rails123_on_o
);

	// ======================================================================
	// Default load strobe
	reg load_q;
	wire [7:0] r6n_q;
	wire [7:0] r6s_q;
	wire [7:0] ldo2_q;
	wire [7:0] ldo3_q;
	wire [7:0] ctrl_q;

	// Load defaults one edge after release, sync for reset
	always @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			load_q <= 1'b1;
		end else begin
			load_q <= 1'b0;
		end
	end

	// ======================================================================
	// Write decode
	wire wr_ok;
	wire wr_r6n;
	wire wr_r6s;
	wire wr_ldo2;
	wire wr_ldo3;
	wire wr_ctrl;

	// Load-cycle writes dropped so a default is never half overwritten
	assign wr_ok = wr_en_i && !load_q;
	assign wr_r6n = wr_ok && (addr_i == `RVM_OFF_RAIL6_NORMAL);
	assign wr_r6s = wr_ok && (addr_i == `RVM_OFF_RAIL6_SLEEP);
	assign wr_ldo2 = wr_ok && (addr_i == `RVM_OFF_LDO2);
	assign wr_ldo3 = wr_ok && (addr_i == `RVM_OFF_LDO3);
	assign wr_ctrl = wr_ok && (addr_i == `RVM_OFF_RAILS123);

	// ======================================================================
	// Register bank
	// Rail6 normal code and fall-mode bit
	rvm_reg8 #(
		.MASK(`RVM_FULL_MASK)
	) u_r6n (
		.clock_i(clock_i),
		.rst_b_i(rst_b_i),
		.load_i(load_q),
		.dflt_i(dflt_rail6_normal_i),
		.wr_i(wr_r6n),
		.wdata_i(wdata_i),
		.q_o(r6n_q)
	);

	// Rail6 sleep code, bit 0 held at zero by the mask
	rvm_reg8 #(
		.MASK(`RVM_SLEEP_MASK)
	) u_r6s (
		.clock_i(clock_i),
		.rst_b_i(rst_b_i),
		.load_i(load_q),
		.dflt_i(dflt_rail6_sleep_i),
		.wr_i(wr_r6s),
		.wdata_i(wdata_i),
		.q_o(r6s_q)
	);

	// LDO2 sleep and normal nibbles
	rvm_reg8 #(
		.MASK(`RVM_FULL_MASK)
	) u_ldo2 (
		.clock_i(clock_i),
		.rst_b_i(rst_b_i),
		.load_i(load_q),
		.dflt_i(dflt_ldo2_i),
		.wr_i(wr_ldo2),
		.wdata_i(wdata_i),
		.q_o(ldo2_q)
	);

	// LDO3 sleep and normal nibbles
	rvm_reg8 #(
		.MASK(`RVM_FULL_MASK)
	) u_ldo3 (
		.clock_i(clock_i),
		.rst_b_i(rst_b_i),
		.load_i(load_q),
		.dflt_i(dflt_ldo3_i),
		.wr_i(wr_ldo3),
		.wdata_i(wdata_i),
		.q_o(ldo3_q)
	);

	// Rails 1-3 mode and allow bits, top two bits held at zero
	rvm_reg8 #(
		.MASK(`RVM_CTRL_MASK)
	) u_ctrl (
		.clock_i(clock_i),
		.rst_b_i(rst_b_i),
		.load_i(load_q),
		.dflt_i(dflt_rails123_i),
		.wr_i(wr_ctrl),
		.wdata_i(wdata_i),
		.q_o(ctrl_q)
	);

	// ======================================================================
	// Sleep and enable pin synchronisers
	reg [2:0] slp_m_q;
	reg [2:0] slp_s_q;
	reg [2:0] en_m_q;
	reg [2:0] en_s_q;

	// Two stages for every pin input
	always @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			slp_m_q <= 3'h0;
			slp_s_q <= 3'h0;
			en_m_q <= 3'h0;
			en_s_q <= 3'h0;
		end else begin
			slp_m_q <= {ldo3_sleep_i, ldo2_sleep_i, rail6_sleep_i};
			slp_s_q <= slp_m_q;
			en_m_q <= rails123_enable_req_i;
			en_s_q <= en_m_q;
		end
	end

	// ======================================================================
	// Read data, registered
	reg [7:0] rdata_d;

	// Address decode for reads
	always @* begin
		case (addr_i)
			`RVM_OFF_RAIL6_NORMAL: rdata_d = r6n_q;
			`RVM_OFF_RAIL6_SLEEP: rdata_d = r6s_q;
			`RVM_OFF_LDO2: rdata_d = ldo2_q;
			`RVM_OFF_LDO3: rdata_d = ldo3_q;
			`RVM_OFF_RAILS123: rdata_d = ctrl_q;
			default: rdata_d = `RVM_UNMAPPED;
		endcase
	end

	// Read data captured on read strobe
	always @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_o <= 8'h00;
		end else if (rd_en_i) begin
			rdata_o <= rdata_d;
		end
	end

	// ======================================================================
	// Regulator controls; nothing enabled until defaults are loaded
	// Rail6 active code follows the synchronised sleep state
	always @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rail6_code_o <= 7'h00;
			rail6_passive_fall_o <= 1'b0;
		end else begin
			rail6_code_o <= slp_s_q[0] ? r6s_q[`RVM_CODE7_HI:`RVM_CODE7_LO] :
				r6n_q[`RVM_CODE7_HI:`RVM_CODE7_LO];
			rail6_passive_fall_o <= r6n_q[`RVM_FALL_BIT];
		end
	end

	// LDO codes: each LDO register holds both, nibble picked by its own sleep state
	always @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ldo2_code_o <= 4'h0;
			ldo3_code_o <= 4'h0;
		end else begin
			ldo2_code_o <= slp_s_q[1] ? ldo2_q[`RVM_SLP4_HI:`RVM_SLP4_LO] :
				ldo2_q[`RVM_NRM4_HI:`RVM_NRM4_LO];
			ldo3_code_o <= slp_s_q[2] ? ldo3_q[`RVM_SLP4_HI:`RVM_SLP4_LO] :
				ldo3_q[`RVM_NRM4_HI:`RVM_NRM4_LO];
		end
	end

	// Rails 1-3: mode bits pass through, allow bit gates the pin request
	always @(posedge clock_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rails123_pwm_force_o <= 3'h0;
			rails123_on_o <= 3'h0;
		end else begin
			rails123_pwm_force_o <= ctrl_q[`RVM_PWM_HI:`RVM_PWM_LO];
			// Allow bit low overrides enable pins
			rails123_on_o <= en_s_q & ctrl_q[`RVM_ALLOW_HI:`RVM_ALLOW_LO] &
				{3{~load_q}};
		end
	end

endmodule // rvm_regs

//--- test/rvm_regs_sva.sv
// Purpose: Port checks on rvm_regs
// Assumes: Hand-over timing
// Notes: Bound at foot
module rvm_regs_sva (
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic [7:0] addr_i,
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	input wire logic [7:0] wdata_i,
	input wire logic ldo2_sleep_i,
	input wire logic [7:0] rdata_o,
	input wire logic [3:0] ldo2_code_o,
	input wire logic [2:0] rails123_pwm_force_o,
	input wire logic [2:0] rails123_on_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);
	// ======
	// Strobes
	wire [7:0] wd = wdata_i;
	wire w_a = wr_en_i && addr_i == 8'h9A;
	wire w_c = wr_en_i && addr_i == 8'h9C;
	// Read path
	hole_rd_a: assert property (
		rd_en_i && addr_i > 8'h9C |=> rdata_o == 8'h00) else $error("hole");
	slp_bit0_a: assert property (
		rd_en_i && addr_i == 8'h99 |=> !rdata_o[0]) else $error("bit0");
	ctl_rsvd_a: assert property (
		rd_en_i && addr_i == 8'h9C |=> rdata_o[7:6] == 2'h0) else $error("rsvd");
	read_back_a: assert property (
		w_a ##1 !wr_en_i ##1 rd_en_i && addr_i == 8'h9A |=> rdata_o == $past(wd, 3)) else $error("rdbk");
	// Outputs
	ldo2_wake_a: assert property (
		!ldo2_sleep_i [*4] ##0 w_a |-> ##2 ldo2_code_o == $past(wd[3:0], 2)) else $error("wake");
	ldo2_slp_a: assert property (
		ldo2_sleep_i [*4] ##0 w_a |-> ##2 ldo2_code_o == $past(wd[7:4], 2)) else $error("slp");
	pwm_mode_a: assert property (
		w_c |-> ##2 rails123_pwm_force_o == $past(wd[5:3], 2)) else $error("pwm");
	allow_off_a: assert property (
		w_c && !wd[0] |-> ##2 !rails123_on_o[0]) else $error("off");
	rd_hold_a: assert property (
		!rd_en_i |=> $stable(rdata_o)) else $error("hold");
	// Coverage
	cover property (w_c);
	cover property (w_a && ldo2_sleep_i);
	cover property (rd_en_i && addr_i > 8'h9C);
endmodule // rvm_regs_sva
bind rvm_regs rvm_regs_sva i_sva (.clock_i(clock_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
	.wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .wdata_i(wdata_i), .ldo2_sleep_i(ldo2_sleep_i),
	.rdata_o(rdata_o), .ldo2_code_o(ldo2_code_o),
	.rails123_pwm_force_o(rails123_pwm_force_o), .rails123_on_o(rails123_on_o));

//--- test/rvm_host.sv
// Purpose: Register port host model
// Assumes: Drives 1 ns after rising edge
// Notes: Idle bus shows inverted values
module rvm_host (
	input wire logic clock_i,
	input wire logic [7:0] rdata_i,
	output logic [7:0] addr_o = 8'h00,
	output logic wr_en_o = 1'b0,
	output logic rd_en_o = 1'b0,
	output logic [7:0] wdata_o = 8'h00
);
	timeunit 1ns;
	timeprecision 1ns;
	// ======
	// One write
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock_i) #1;
		{addr_o, wdata_o, wr_en_o} = {a, d, 1'b1};
		@(posedge clock_i) #1;
		{addr_o, wdata_o, wr_en_o} = {~a, ~d, 1'b0};
	endtask
	// One read, data one edge later
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock_i) #1;
		{addr_o, rd_en_o} = {a, 1'b1};
		@(posedge clock_i) #1;
		{addr_o, rd_en_o} = {~a, 1'b0};
		d = rdata_i;
	endtask
endmodule // rvm_host

//--- test/rvm_regs_tb_top.sv
// Purpose: rvm_regs bench
// Assumes: Host model on register port
// Notes: Fixed defaults
module rvm_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	// ======
	logic clock_i = 0, rst_b_i = 0, wr_en_i, rd_en_i, rail6_passive_fall_o;
	logic rail6_sleep_i = 0, ldo2_sleep_i = 1, ldo3_sleep_i = 0;
	logic [7:0] addr_i, wdata_i, rdata_o, q;
	logic [6:0] rail6_code_o;
	logic [3:0] ldo2_code_o, ldo3_code_o;
	logic [2:0] rails123_pwm_force_o, rails123_on_o, rails123_enable_req_i = 3'h7;
	int bad_count = 0, compares = 0;
	logic [7:0] dv [5] = '{8'hBE, 8'hBF, 8'hA5, 8'h3C, 8'hFF};
	logic [7:0] mk [6] = '{8'hFF, 8'hFE, 8'hFF, 8'hFF, 8'h3F, 8'h00};
	always #20 clock_i = ~clock_i;
	rvm_host i_host (.clock_i(clock_i), .rdata_i(rdata_o), .addr_o(addr_i),
		.wr_en_o(wr_en_i), .rd_en_o(rd_en_i), .wdata_o(wdata_i));
	rvm_regs i_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
		.wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .wdata_i(wdata_i),
		.dflt_rail6_normal_i(dv[0]), .dflt_rail6_sleep_i(dv[1]),
		.dflt_ldo2_i(dv[2]), .dflt_ldo3_i(dv[3]), .dflt_rails123_i(dv[4]),
		.rail6_sleep_i(rail6_sleep_i), .ldo2_sleep_i(ldo2_sleep_i),
		.ldo3_sleep_i(ldo3_sleep_i), .rails123_enable_req_i(rails123_enable_req_i),
		.rdata_o(rdata_o), .rail6_code_o(rail6_code_o),
		.rail6_passive_fall_o(rail6_passive_fall_o),
		.ldo2_code_o(ldo2_code_o), .ldo3_code_o(ldo3_code_o),
		.rails123_pwm_force_o(rails123_pwm_force_o), .rails123_on_o(rails123_on_o));
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		compares++;
		if (s !== e) begin
			bad_count++;
			$display("MISMATCH %0t got %h exp %h", $time, s, e);
		end
	endtask
	task automatic tally_and_finish;
		$display("compares %0d bad %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Defaults, reserved bits cleared
	task automatic t_dflt;
		for (int i = 0; i < 5; i++) begin
			i_host.rd(8'h98 + i[7:0], q);
			chk(q, dv[i] & mk[i]);
		end
	endtask
	// Write then read, hole at 9Dh
	task automatic t_rw;
		for (int i = 0; i < 6; i++) begin
			i_host.wr(8'h98 + i[7:0], 8'h5A ^ i[7:0]);
			i_host.rd(8'h98 + i[7:0], q);
			chk(q, (8'h5A ^ i[7:0]) & mk[i]);
		end
	endtask
	// Codes follow sleep state
	task automatic t_sleep;
		{rail6_sleep_i, ldo2_sleep_i, ldo3_sleep_i} = 3'h0;
		repeat (5) @(posedge clock_i);
		i_host.wr(8'h98, 8'h55);
		i_host.wr(8'h99, 8'h80);
		i_host.wr(8'h9A, 8'h3C);
		i_host.wr(8'h9B, 8'hC3);
		repeat (3) @(posedge clock_i) #1;
		chk({rail6_code_o, rail6_passive_fall_o}, 8'h55);
		chk({ldo2_code_o, ldo3_code_o}, 8'hC3);
		{rail6_sleep_i, ldo2_sleep_i, ldo3_sleep_i} = 3'h2;
		repeat (5) @(posedge clock_i) #1;
		chk({rail6_code_o, rail6_passive_fall_o}, 8'h55);
		chk({ldo2_code_o, ldo3_code_o}, 8'h33);
		{rail6_sleep_i, ldo2_sleep_i, ldo3_sleep_i} = 3'h7;
		repeat (5) @(posedge clock_i) #1;
		chk({rail6_code_o, rail6_passive_fall_o}, 8'h81);
		chk({ldo2_code_o, ldo3_code_o}, 8'h3C);
	endtask
	// Mode and allow bits
	task automatic t_ctrl;
		i_host.wr(8'h9C, 8'h33);
		repeat (4) @(posedge clock_i) #1;
		chk({2'h0, rails123_pwm_force_o, rails123_on_o}, 8'h33);
		rails123_enable_req_i = 3'h6;
		repeat (5) @(posedge clock_i) #1;
		chk({5'h0, rails123_on_o}, 8'h02);
	endtask
	// Mid-run reset clears outputs, then defaults come back
	task automatic t_rst;
		rst_b_i = 1'b0;
		#1;
		chk({rail6_code_o, rail6_passive_fall_o}, 8'h00);
		chk({5'h0, rails123_on_o}, 8'h00);
		repeat (3) @(posedge clock_i) #1;
		rst_b_i = 1'b1;
		t_dflt();
	endtask
	initial begin
		repeat (16) @(posedge clock_i) #1;
		rst_b_i = 1'b1;
		t_dflt();
		t_rw();
		t_sleep();
		t_ctrl();
		t_rst();
		tally_and_finish();
	end
	// Watchdog
	initial begin
		#20000;
		bad_count++;
		tally_and_finish();
	end
endmodule // rvm_regs_tb_top
